// ==== core/dte_port_supervision.v ====
// DTE port supervision: clocking, lead monitoring, tests and LMI settings
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "dte_port_defs.vh"

module dte_port_supervision #(
	parameter SEC_CYCLES = `SEC_CYCLES
) (
	// Clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// DTE pins
	input  wire        rts_in,
	input  wire        dtr_in,
	input  wire        local_loop_request_lead,
	input  wire        dte_ext_tx_clock,
	input  wire        tx_data_in,
	output reg         dce_tx_timing_clock,
	output reg         cts_out,
	// Port data and state
	output reg         rx_data,
	output reg         rx_data_valid,
	output reg         data_enable,
	output reg         dtr_alarm,
	output reg         lmi_down,
	output reg         loop_active,
	output reg         pattern_active,
	// LMI engine side
	input  wire        lmi_poll_valid,
	input  wire [1:0]  lmi_poll_variant,
	input  wire        lmi_msg_error,
	input  wire        lmi_msg_ok,
	input  wire        lmi_enq_rx,
	input  wire        lmi_capture_active,
	output reg  [1:0]  lmi_variant,
	output reg         lmi_error,
	output reg  [3:0]  lmi_n2,
	output reg  [3:0]  lmi_n3,
	output reg  [4:0]  lmi_t2_sec,
	output reg  [4:0]  lmi_t3_sec
);

	function [6:0] clamp;
		input [6:0] v;
		input [6:0] lo;
		input [6:0] hi;
		begin
			if (v < lo)
				clamp = lo;
			else if (v > hi)
				clamp = hi;
			else
				clamp = v;
		end
	endfunction

	// Registers
	reg  [10:0] ctrl_q;
	reg  [6:0]  dur_q;
	reg  [26:0] lmi_cus_q;
	reg  [26:0] lmi_sys_q;
	reg  [7:0]  enq_count_q;

	// Synchronisers: rts, dtr, loop lead, ext clock, data
	reg  [4:0]  s1_q;
	reg  [4:0]  s2_q;
	reg  [4:0]  s3_q;
	wire        rts_s   = s2_q[0];
	wire        dtr_s   = s2_q[1];
	wire        td_s    = s2_q[4];
	wire        loop_rise = s2_q[2] & ~s3_q[2];
	wire        loop_fall = ~s2_q[2] & s3_q[2];
	wire        xclk_rise = s2_q[3] & ~s3_q[3];
	wire        td_edge = s2_q[4] ^ s3_q[4];

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= 5'h00;
			s2_q <= 5'h00;
			s3_q <= 5'h00;
		end else begin
			s1_q <= {tx_data_in, dte_ext_tx_clock, local_loop_request_lead,
				dtr_in, rts_in};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// APB access
	wire        acc     = psel & penable & pready;
	wire        wr      = acc & pwrite;
	wire        wr_ctrl = wr & (paddr == `OFS_CTRL);
	wire        wr_cmd  = wr & (paddr == `OFS_TEST_CMD);
	wire        src_chg = wr_ctrl &
		(pwdata[`CTRL_CLK_EXT] != ctrl_q[`CTRL_CLK_EXT]);
	wire        mode_chg = wr_ctrl &
		(pwdata[`CTRL_LMI_HI:`CTRL_LMI_LO] !=
		 ctrl_q[`CTRL_LMI_HI:`CTRL_LMI_LO]);

	// Effective lead states
	wire rts_eff = rts_s | ~ctrl_q[`CTRL_RTS_MON];
	wire dtr_eff = dtr_s | ~ctrl_q[`CTRL_DTR_MON];

	// Second tick
	reg  [24:0] pre_q;
	wire        sec_tick = ({7'h00, pre_q} == SEC_CYCLES - 1);

	// Test state
	reg         test_q;
	reg         pat_q;
	reg         dte_loop_q;
	reg  [12:0] test_sec_q;
	reg         tmo_seen_q;
	wire [12:0] test_limit = {6'h00, dur_q} * `SECS_PER_MIN;
	wire        tmo_hit = test_q & ctrl_q[`CTRL_TMO_EN] & sec_tick &
		(test_sec_q + 13'h0001 >= test_limit);

	// Clock phase and inversion
	reg  [2:0]  ph_q;
	reg         auto_inv_q;
	reg  [3:0]  viol_q;
	wire [2:0]  ph_d = ph_q + 3'h1;
	wire        near_sample = (ph_q == 3'h3) | (ph_q == 3'h4) |
		(ph_q == 3'h5);
	reg         inv;

	always @* begin
		case (ctrl_q[`CTRL_INV_HI:`CTRL_INV_LO])
			`INV_ON:  inv = 1'b1;
			`INV_OFF: inv = 1'b0;
			default:  inv = auto_inv_q;
		endcase
	end

	wire sample = ctrl_q[`CTRL_CLK_EXT] ? xclk_rise :
		(ph_q == 3'h4);

	// Effective LMI parameters
	wire [26:0] lmi_sel = ctrl_q[`CTRL_LMI_CUSTOM] ? lmi_cus_q :
		lmi_sys_q;
	wire [6:0]  n2_c = clamp({3'h0, lmi_sel[3:0]}, `N_MIN, `N_MAX);
	wire [6:0]  n3_c = clamp({3'h0, lmi_sel[11:8]}, `N_MIN, `N_MAX);
	wire [6:0]  t2_c = clamp({4'h0, lmi_sel[18:16]}, `STEP_MIN,
		`STEP_MAX);
	wire [6:0]  t3_c = clamp({4'h0, lmi_sel[26:24]}, `STEP_MIN,
		`STEP_MAX);
	wire [4:0]  t2_secs = t2_c[4:0] * `STEP_SECS;
	wire [4:0]  t3_secs = t3_c[4:0] * `STEP_SECS;

	// LMI supervision
	reg  [3:0]  err_cnt_q;
	reg  [3:0]  ok_cnt_q;
	reg         learned_q;
	reg  [4:0]  enq_sec_q;
	reg  [4:0]  win_sec_q;
	reg  [7:0]  win_cnt_q;
	reg         enq_miss_q;
	reg         link_down_q;
	wire        enq_late = sec_tick & (enq_sec_q + 5'h01 >= t2_secs);
	wire        any_err = lmi_msg_error | enq_miss_q;
	wire        link_down_d = lmi_error | ~rts_eff | ~dtr_eff;
	wire [2:0]  lmi_mode = ctrl_q[`CTRL_LMI_HI:`CTRL_LMI_LO];

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_q        <= 25'h0000000;
			ctrl_q       <= `CTRL_RESET;
			dur_q        <= `DUR_RESET;
			lmi_cus_q    <= `LMI_RESET;
			lmi_sys_q    <= `LMI_RESET;
			test_q       <= 1'b0;
			pat_q        <= 1'b0;
			dte_loop_q   <= 1'b0;
			test_sec_q   <= 13'h0000;
			tmo_seen_q   <= 1'b0;
			ph_q         <= 3'h0;
			auto_inv_q   <= 1'b0;
			viol_q       <= 4'h0;
			err_cnt_q    <= 4'h0;
			ok_cnt_q     <= 4'h0;
			learned_q    <= 1'b0;
			enq_sec_q    <= 5'h00;
			win_sec_q    <= 5'h00;
			win_cnt_q    <= 8'h00;
			enq_count_q  <= 8'h00;
			enq_miss_q   <= 1'b0;
			link_down_q  <= 1'b0;
		end else begin
			pre_q <= sec_tick ? 25'h0000000 : pre_q + 25'h0000001;
			ph_q  <= ph_d;
			// Register writes
			if (wr_ctrl)
				ctrl_q <= pwdata[10:0];
			if (wr & (paddr == `OFS_TEST_DUR))
				dur_q <= (pwdata[31:7] != 25'h0000000) ? `DUR_MAX :
					clamp(pwdata[6:0], `DUR_MIN, `DUR_MAX);
			if (wr & (paddr == `OFS_LMI_CUSTOM))
				lmi_cus_q <= pwdata[26:0];
			if (wr & (paddr == `OFS_LMI_SYSTEM))
				lmi_sys_q <= pwdata[26:0];
			// User tests: start, stop, timeout, source-change abort
			if (src_chg | tmo_hit | (wr_cmd & pwdata[`CMD_STOP])) begin
				test_q <= 1'b0;
				pat_q  <= 1'b0;
			end else if (wr_cmd & (pwdata[`CMD_LOOP] |
				pwdata[`CMD_PATTERN])) begin
				test_q <= 1'b1;
				pat_q  <= pwdata[`CMD_PATTERN] & ~pwdata[`CMD_LOOP];
			end
			if (tmo_hit)
				tmo_seen_q <= 1'b1;
			else if (wr_cmd)
				tmo_seen_q <= 1'b0;
			// Timer only runs for user tests; DTE loops never time out
			if (wr_cmd | ~test_q)
				test_sec_q <= 13'h0000;
			else if (sec_tick)
				test_sec_q <= test_sec_q + 13'h0001;
			// DTE loopback follows lead edges, so an abort holds until re-raised
			if (src_chg | ~ctrl_q[`CTRL_DTE_LOOP] | loop_fall)
				dte_loop_q <= 1'b0;
			else if (loop_rise)
				dte_loop_q <= 1'b1;
			// Auto inversion: flip after 16 data edges too close to sampling
			if (td_edge & ~ctrl_q[`CTRL_CLK_EXT]) begin
				if (near_sample) begin
					if (viol_q == 4'hF) begin
						auto_inv_q <= ~auto_inv_q;
						viol_q     <= 4'h0;
					end else begin
						viol_q <= viol_q + 4'h1;
					end
				end else begin
					viol_q <= 4'h0;
				end
			end
			// LMI error reporting and clearing
			if (~lmi_error) begin
				if (lmi_msg_ok)
					err_cnt_q <= 4'h0;
				else if (any_err)
					err_cnt_q <= err_cnt_q + 4'h1;
				ok_cnt_q <= 4'h0;
			end else begin
				err_cnt_q <= 4'h0;
				if (any_err)
					ok_cnt_q <= 4'h0;
				else if (lmi_msg_ok)
					ok_cnt_q <= ok_cnt_q + 4'h1;
			end
			// Enquiry expectation and measurement window
			enq_miss_q <= enq_late & ~lmi_enq_rx;
			if (lmi_enq_rx | enq_late)
				enq_sec_q <= 5'h00;
			else if (sec_tick)
				enq_sec_q <= enq_sec_q + 5'h01;
			if (sec_tick & (win_sec_q + 5'h01 >= t3_secs)) begin
				win_sec_q   <= 5'h00;
				enq_count_q <= win_cnt_q +
					{7'h00, lmi_enq_rx & (win_cnt_q != 8'hFF)};
				win_cnt_q   <= 8'h00;
			end else begin
				if (sec_tick)
					win_sec_q <= win_sec_q + 5'h01;
				if (lmi_enq_rx & (win_cnt_q != 8'hFF))
					win_cnt_q <= win_cnt_q + 8'h01;
			end
			// Variant discovery
			link_down_q <= link_down_d;
			if (mode_chg | ((lmi_mode == `LMI_RELEARN) & link_down_d &
				~link_down_q))
				learned_q <= 1'b0;
			else if (lmi_poll_valid & ((lmi_mode == `LMI_INIT_IF) |
				(lmi_mode == `LMI_RELEARN)))
				learned_q <= 1'b1;
		end
	end

	// Registered outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata              <= 32'h00000000;
			pready              <= 1'b0;
			pslverr             <= 1'b0;
			dce_tx_timing_clock <= 1'b0;
			cts_out             <= 1'b0;
			rx_data             <= 1'b0;
			rx_data_valid       <= 1'b0;
			data_enable         <= 1'b0;
			dtr_alarm           <= 1'b0;
			lmi_down            <= 1'b0;
			loop_active         <= 1'b0;
			pattern_active      <= 1'b0;
			lmi_variant         <= `VAR_STD;
			lmi_error           <= 1'b0;
			lmi_n2              <= 4'h3;
			lmi_n3              <= 4'h1;
			lmi_t2_sec          <= 5'h0F;
			lmi_t3_sec          <= 5'h14;
		end else begin
			// Answer in the first access cycle; data prepared during setup
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & (paddr > `OFS_ENQ_COUNT |
				paddr[1:0] != 2'h0);
			if (psel & ~penable & ~pwrite) begin
				case (paddr)
					`OFS_CTRL:       prdata <= {21'h000000, ctrl_q};
					`OFS_TEST_DUR:   prdata <= {25'h0000000, dur_q};
					`OFS_LMI_CUSTOM: prdata <= {5'h00, lmi_cus_q};
					`OFS_LMI_SYSTEM: prdata <= {5'h00, lmi_sys_q};
					`OFS_STATUS:     prdata <= {19'h00000, tmo_seen_q,
						learned_q, lmi_variant, lmi_error, auto_inv_q,
						data_enable, lmi_down, dtr_alarm, cts_out,
						dte_loop_q, pat_q, test_q};
					`OFS_ENQ_COUNT:  prdata <= {24'h000000, enq_count_q};
					default:         prdata <= 32'h00000000;
				endcase
			end
			dce_tx_timing_clock <= ph_d[2] ^ inv;
			cts_out     <= rts_eff;
			dtr_alarm   <= ~dtr_eff;
			lmi_down    <= link_down_d;
			data_enable <= rts_eff & dtr_eff;
			rx_data_valid <= sample & rts_eff & dtr_eff;
			if (sample)
				rx_data <= td_s;
			loop_active    <= (test_q & ~pat_q) | dte_loop_q;
			pattern_active <= test_q & pat_q;
			if (lmi_error) begin
				if (~any_err & lmi_msg_ok & (ok_cnt_q + 4'h1 >= n3_c[3:0]))
					lmi_error <= 1'b0;
			end else if (any_err & ~lmi_msg_ok &
				(err_cnt_q + 4'h1 >= n2_c[3:0])) begin
				lmi_error <= 1'b1;
			end
			case (lmi_mode)
				`LMI_FIX_STD: lmi_variant <= `VAR_STD;
				`LMI_FIX_A:   lmi_variant <= `VAR_ANNEX_A;
				`LMI_FIX_D:   lmi_variant <= `VAR_ANNEX_D;
				default: begin
					if (lmi_poll_valid & ~learned_q)
						lmi_variant <= lmi_poll_variant;
				end
			endcase
			lmi_n2     <= n2_c[3:0];
			lmi_n3     <= n3_c[3:0];
			lmi_t2_sec <= t2_secs;
			lmi_t3_sec <= t3_secs;
		end
	end

endmodule

// ==== inc/dte_port_defs.vh ====
// Constants for the DTE port supervision block
`ifndef DTE_PORT_DEFS_VH
`define DTE_PORT_DEFS_VH

// Timing
`define CLK_HZ          25000000
`define SEC_TIME_S      1
`define SEC_CYCLES      (`CLK_HZ * `SEC_TIME_S)
`define SECS_PER_MIN    13'h03C

// Register byte offsets
`define OFS_CTRL        12'h000
`define OFS_TEST_DUR    12'h004
`define OFS_LMI_CUSTOM  12'h008
`define OFS_LMI_SYSTEM  12'h00C
`define OFS_TEST_CMD    12'h010
`define OFS_STATUS      12'h014
`define OFS_ENQ_COUNT   12'h018

// Control register fields
`define CTRL_TMO_EN     0
`define CTRL_CLK_EXT    1
`define CTRL_INV_LO     2
`define CTRL_INV_HI     3
`define CTRL_RTS_MON    4
`define CTRL_DTR_MON    5
`define CTRL_DTE_LOOP   6
`define CTRL_LMI_LO     7
`define CTRL_LMI_HI     9
`define CTRL_LMI_CUSTOM 10
`define CTRL_RESET      11'h031

// Invert modes
`define INV_AUTO        2'h0
`define INV_ON          2'h1
`define INV_OFF         2'h2

// LMI modes and variants
`define LMI_INIT_IF     3'h0
`define LMI_RELEARN     3'h1
`define LMI_FIX_STD     3'h2
`define LMI_FIX_A       3'h3
`define LMI_FIX_D       3'h4
`define VAR_STD         2'h0
`define VAR_ANNEX_A     2'h1
`define VAR_ANNEX_D     2'h2

// Test duration (minutes)
`define DUR_MIN         7'h01
`define DUR_MAX         7'h78
`define DUR_RESET       7'h0A

// LMI parameter fields: n2 [3:0], n3 [11:8], t2 step [18:16], t3 step [26:24]
`define LMI_RESET       27'h4030103
`define N_MIN           7'h01
`define N_MAX           7'h0A
`define STEP_MIN        7'h01
`define STEP_MAX        7'h06
`define STEP_SECS       5'h05

// Test command bits
`define CMD_LOOP        0
`define CMD_PATTERN     1
`define CMD_STOP        2

`endif

// ==== verification/dte_port_assertions.sv ====
// Port-level assertions for the DTE port supervision block
`timescale 1ns/1ps
module dte_port_checker (
	// Clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// APB
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	// Port state
	input wire logic       cts_out,
	input wire logic       data_enable,
	input wire logic       lmi_down,
	input wire logic       dtr_alarm,
	// LMI
	input wire logic       lmi_msg_error,
	input wire logic       lmi_msg_ok,
	input wire logic       lmi_error,
	input wire logic [3:0] lmi_n2,
	input wire logic [3:0] lmi_n3,
	input wire logic [4:0] lmi_t2_sec
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_one_access;
		psel && penable ##1 !pready;
	endsequence
	a_ready_after_setup: assert property (s_setup |=> pready)
		else $error("pready missing after setup");
	a_ready_one_pulse: assert property (pready |-> s_one_access)
		else $error("pready outside a single access cycle");
	a_data_needs_cts: assert property (data_enable |-> cts_out)
		else $error("data enabled without clear-to-send");
	a_down_blocks_data: assert property (
		$fell(cts_out) |-> lmi_down && !data_enable)
		else $error("data enabled while link down");
	a_alarm_means_down: assert property (
		dtr_alarm |-> lmi_down && !data_enable)
		else $error("terminal-ready alarm without link down");
	a_error_at_n2: assert property (
		lmi_msg_error && lmi_n2 == 4'h1 |=> lmi_error)
		else $error("error not reported at count one");
	a_clear_at_n3: assert property (
		lmi_error && lmi_msg_ok && lmi_n3 == 4'h1 |=> !lmi_error)
		else $error("error not cleared after one good message");
	a_param_range: assert property (lmi_n2 >= 4'h1 && lmi_n2 <= 4'hA
		&& lmi_t2_sec >= 5'h05 && lmi_t2_sec <= 5'h1E)
		else $error("effective LMI parameter out of range");
endmodule

bind dte_port_supervision dte_port_checker i_dte_port_checker (
	.pclk, .presetn, .psel, .penable, .pready, .cts_out, .data_enable,
	.lmi_down, .dtr_alarm, .lmi_msg_error, .lmi_msg_ok, .lmi_error,
	.lmi_n2, .lmi_n3, .lmi_t2_sec);

// ==== verification/dte_model.sv ====
// Behavioural DTE attached to the user data port
`timescale 1ns/1ps
module dte_model (
	// Bench controls
	input  wire logic rts_on,
	input  wire logic dtr_on,
	input  wire logic loop_on,
	input  wire logic ext_run,
	// Device side
	input  wire logic dce_tx_timing_clock,
	output wire logic rts_in,
	output wire logic dtr_in,
	output wire logic local_loop_request_lead,
	output logic      dte_ext_tx_clock,
	output wire logic tx_data_in
);
	logic td_q = 1'b0;
	assign tx_data_in = td_q;
	assign rts_in = rts_on;
	assign dtr_in = dtr_on;
	assign local_loop_request_lead = loop_on;
	// Own clock, unrelated in phase to pclk, parked low when not running
	initial begin
		dte_ext_tx_clock = 1'b0;
		#7;
		forever begin
			#160;
			dte_ext_tx_clock = ext_run & ~dte_ext_tx_clock;
		end
	end
	// New bit on each falling edge so it is settled at the sampling rise
	always @(negedge dce_tx_timing_clock or negedge dte_ext_tx_clock)
		td_q <= ~td_q;
endmodule

// ==== verification/dte_port_supervision_tb.sv ====
// Self-checking bench for the DTE port supervision block
`timescale 1ns/1ps
`include "dte_port_defs.vh"
module dte_port_supervision_tb;
	logic        pclk = 1'b0, presetn = 1'b0, er, v0, v1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic        pready, pslverr, rts_in, dtr_in, local_loop_request_lead;
	logic        dte_ext_tx_clock, tx_data_in, dce_tx_timing_clock, cts_out;
	logic        rx_data, rx_data_valid, data_enable, dtr_alarm, lmi_down;
	logic        loop_active, pattern_active, lmi_error, lmi_enq_rx = 1'b0;
	logic        lmi_poll_valid = 1'b0, lmi_msg_error = 1'b0, lmi_msg_ok = 1'b0;
	logic [1:0]  lmi_poll_variant = 2'h0, lmi_variant;
	logic [3:0]  lmi_n2, lmi_n3;
	logic [4:0]  lmi_t2_sec, lmi_t3_sec;
	logic        rts_on = 1'b1, dtr_on = 1'b1, loop_on = 1'b0, ext_run = 1'b0;
	logic [5:0]  ec = 6'h00;
	int          n_fail = 0, n_compared = 0, c, same;

	dte_port_supervision #(.SEC_CYCLES(20)) i_dte_port_supervision (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .rts_in, .dtr_in, .local_loop_request_lead,
		.dte_ext_tx_clock, .tx_data_in, .dce_tx_timing_clock, .cts_out,
		.rx_data, .rx_data_valid, .data_enable, .dtr_alarm, .lmi_down,
		.loop_active, .pattern_active, .lmi_poll_valid, .lmi_poll_variant,
		.lmi_msg_error, .lmi_msg_ok, .lmi_enq_rx, .lmi_capture_active(1'b0),
		.lmi_variant, .lmi_error, .lmi_n2, .lmi_n3, .lmi_t2_sec, .lmi_t3_sec);
	dte_model i_dte_model (.rts_on, .dtr_on, .loop_on, .ext_run,
		.dce_tx_timing_clock, .rts_in, .dtr_in, .local_loop_request_lead,
		.dte_ext_tx_clock, .tx_data_in);

	always #20 pclk = ~pclk;
	// Enquiries every 64 cycles, well inside the shortest heartbeat
	always @(posedge pclk) begin
		ec <= ec + 6'h01;
		lmi_enq_rx <= &ec;
	end

	task automatic give_verdict;
		$display("compared %0d mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int i;
		i = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		q = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Outputs registered from a write show at the idle edge, one edge before the check
		repeat (2) @(posedge pclk);
		if (i >= 20) begin
			n_fail++;
			give_verdict;
		end
	endtask
	task automatic rd(input string nm, input logic [11:0] a,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, q, e);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic lds(input logic [2:0] e);
		wt(8);
		chk("leads", 32'({lmi_down, data_enable, dtr_alarm}), 32'(e));
	endtask
	task automatic ev(input logic e, input logic o, input logic p,
		input logic [1:0] v);
		lmi_msg_error <= e;
		lmi_msg_ok <= o;
		lmi_poll_valid <= p;
		lmi_poll_variant <= v;
		@(posedge pclk);
		lmi_msg_error <= 1'b0;
		lmi_msg_ok <= 1'b0;
		lmi_poll_valid <= 1'b0;
		wt(2);
	endtask
	task automatic cntv;
		logic pv;
		pv = 1'b0;
		c = 0;
		same = 0;
		wt(20);
		repeat (320) begin
			@(posedge pclk);
			if (rx_data_valid === 1'b1) begin
				if (c > 0 && rx_data === pv)
					same++;
				pv = rx_data;
				c++;
			end
		end
	endtask
	task automatic ph(output logic v);
		int i;
		i = 0;
		wt(20);
		do begin
			@(posedge pclk);
			i++;
		end while (rx_data_valid !== 1'b1 && i < 50);
		v = dce_tx_timing_clock;
		if (i >= 50) begin
			n_fail++;
			give_verdict;
		end
	endtask

	initial begin
		wt(3);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("n2n3", 32'({lmi_n2, lmi_n3}), 32'h31);
		chk("t2", 32'(lmi_t2_sec), 32'd15);
		chk("t3", 32'(lmi_t3_sec), 32'd20);
		rd("ctrl", 12'h000, 32'(`CTRL_RESET));
		rd("dur", 12'h004, 32'(`DUR_RESET));
		rd("sys", 12'h00C, 32'(`LMI_RESET));
		rd("hole", 12'h01C, 32'h0);
		chk("slverr", 32'(er), 32'h1);
		apb(1'b1, 12'h004, 32'h0);
		rd("durlo", 12'h004, 32'h1);
		apb(1'b1, 12'h004, 32'd200);
		rd("durhi", 12'h004, 32'(`DUR_MAX));
		rts_on <= 1'b0;
		lds(3'b100);
		chk("cts", 32'(cts_out), 32'h0);
		rts_on <= 1'b1;
		lds(3'b010);
		chk("cts", 32'(cts_out), 32'h1);
		dtr_on <= 1'b0;
		lds(3'b101);
		apb(1'b1, 12'h000, 32'h001);
		rts_on <= 1'b0;
		lds(3'b010);
		chk("cts", 32'(cts_out), 32'h1);
		rts_on <= 1'b1;
		dtr_on <= 1'b1;
		apb(1'b1, 12'h004, 32'h1);
		apb(1'b1, 12'h000, 32'h031);
		apb(1'b1, 12'h010, 32'h2);
		wt(1100);
		chk("pat", 32'(pattern_active), 32'h1);
		wt(150);
		chk("pat", 32'(pattern_active), 32'h0);
		apb(1'b1, 12'h010, 32'h1);
		wt(1100);
		chk("loop", 32'(loop_active), 32'h1);
		apb(1'b1, 12'h010, 32'h4);
		chk("loop", 32'(loop_active), 32'h0);
		apb(1'b1, 12'h000, 32'h030);
		apb(1'b1, 12'h010, 32'h2);
		wt(1300);
		chk("pat", 32'(pattern_active), 32'h1);
		apb(1'b1, 12'h010, 32'h4);
		chk("pat", 32'(pattern_active), 32'h0);
		apb(1'b1, 12'h000, 32'h071);
		loop_on <= 1'b1;
		wt(1300);
		chk("dteloop", 32'(loop_active), 32'h1);
		loop_on <= 1'b0;
		wt(8);
		chk("dteloop", 32'(loop_active), 32'h0);
		apb(1'b1, 12'h000, 32'h031);
		loop_on <= 1'b1;
		wt(8);
		chk("ignored", 32'(loop_active), 32'h0);
		loop_on <= 1'b0;
		apb(1'b1, 12'h000, 32'h071);
		loop_on <= 1'b1;
		wt(8);
		apb(1'b1, 12'h000, 32'h073);
		chk("abort", 32'(loop_active), 32'h0);
		loop_on <= 1'b0;
		cntv;
		chk("extstill", 32'(c), 32'h0);
		ext_run <= 1'b1;
		cntv;
		chk("ext", 32'(c > 37 && c < 42), 32'h1);
		ext_run <= 1'b0;
		apb(1'b1, 12'h000, 32'h035);
		cntv;
		chk("int", 32'(c > 37 && c < 42), 32'h1);
		chk("rxalt", 32'(same), 32'h0);
		ph(v0);
		apb(1'b1, 12'h000, 32'h039);
		ph(v1);
		chk("invert", 32'(v0 ^ v1), 32'h1);
		apb(1'b1, 12'h000, 32'h031);
		ev(1'b0, 1'b0, 1'b1, 2'h2);
		ev(1'b0, 1'b0, 1'b1, 2'h1);
		chk("var", 32'(lmi_variant), 32'h2);
		apb(1'b1, 12'h000, 32'h0B1);
		ev(1'b0, 1'b0, 1'b1, 2'h1);
		ev(1'b0, 1'b0, 1'b1, 2'h2);
		chk("var", 32'(lmi_variant), 32'h1);
		rts_on <= 1'b0;
		wt(8);
		rts_on <= 1'b1;
		wt(8);
		ev(1'b0, 1'b0, 1'b1, 2'h2);
		chk("var", 32'(lmi_variant), 32'h2);
		for (int m = 2; m < 5; m++) begin
			apb(1'b1, 12'h000, 32'h031 | (m << 7));
			chk("fixvar", 32'(lmi_variant), 32'(m - 2));
		end
		apb(1'b1, 12'h000, 32'h031);
		ev(1'b1, 1'b0, 1'b0, 2'h0);
		ev(1'b1, 1'b0, 1'b0, 2'h0);
		chk("err", 32'(lmi_error), 32'h0);
		ev(1'b1, 1'b0, 1'b0, 2'h0);
		chk("err", 32'(lmi_error), 32'h1);
		ev(1'b0, 1'b1, 1'b0, 2'h0);
		chk("err", 32'(lmi_error), 32'h0);
		apb(1'b0, 12'h018, 32'h0);
		chk("enq", 32'(q >= 32'd6 && q <= 32'd7), 32'h1);
		apb(1'b1, 12'h008, 32'h0);
		apb(1'b1, 12'h000, 32'h431);
		chk("custom", 32'({lmi_n2, lmi_t2_sec}), 32'h25);
		ev(1'b1, 1'b0, 1'b0, 2'h0);
		chk("err", 32'(lmi_error), 32'h1);
		ev(1'b0, 1'b1, 1'b0, 2'h0);
		chk("err", 32'(lmi_error), 32'h0);
		give_verdict;
	end
endmodule
